// [rle_regs.vh]
`ifndef RLE_REGS_VH
`define RLE_REGS_VH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define RLE_OP_W        5
`define RLE_OP_NOP      5'h00
`define RLE_OP_ADD      5'h01
`define RLE_OP_SUB      5'h02
`define RLE_OP_RSUB     5'h03
`define RLE_OP_INCR     5'h04
`define RLE_OP_DECR     5'h05
`define RLE_OP_ADDINCR  5'h06
`define RLE_OP_SUBDECR  5'h07
`define RLE_OP_RSUBDECR 5'h08
`define RLE_OP_CLEAR    5'h09
`define RLE_OP_SET      5'h0a
`define RLE_OP_INVERT   5'h0b
`define RLE_OP_AND      5'h0c
`define RLE_OP_NAND     5'h0d
`define RLE_OP_OR       5'h0e
`define RLE_OP_NOR      5'h0f
`define RLE_OP_XOR      5'h10
`define RLE_OP_EQUIV    5'h11
`define RLE_OP_ANDREV   5'h12
`define RLE_OP_ANDINV   5'h13
`define RLE_OP_ORREV    5'h14
`define RLE_OP_ORINV    5'h15
`define RLE_OP_MOVE     5'h16
`define RLE_OP_MOVI     5'h17
`define RLE_OP_SWAP     5'h18
`define RLE_OP_STD      5'h19
`define RLE_OP_PUSH     5'h1a
`define RLE_OP_POP      5'h1b
`define RLE_OP_ADDR2D   5'h1c
`define RLE_OP_ADDR3D   5'h1d

// ----------------------------------------
// Lane sizes
// ----------------------------------------
`define RLE_SIZE_32     2'h0
`define RLE_SIZE_16     2'h1
`define RLE_SIZE_8      2'h2

// ----------------------------------------
// Packed address fields
// ----------------------------------------
`define RLE_A2_X_HI     31
`define RLE_A2_X_LO     16
`define RLE_A2_Y_HI     15
`define RLE_A2_Y_LO     0
`define RLE_A3_X_HI     23
`define RLE_A3_X_LO     16
`define RLE_A3_Y_HI     15
`define RLE_A3_Y_LO     8
`define RLE_A3_Z_HI     7
`define RLE_A3_Z_LO     0

// ----------------------------------------
// Stack and reset
// ----------------------------------------
`define RLE_WORD_BYTES  32'h00000004
`define RLE_MAX_REGS    8
`define RLE_RESET_WORD  32'h00000000
`endif

// [rle_lane_alu.v]
`timescale 1ns/1ps
`include "rle_regs.vh"
module rle_lane_alu (
	input  wire [`RLE_OP_W-1:0] i_op,
	input  wire [1:0]           i_size,
	input  wire [31:0]          i_a,
	input  wire [31:0]          i_b,
	output reg  [31:0]          o_y
);
	// ----------------------------------------
	// Byte slice adder with lane-gated carries
	// ----------------------------------------
	reg  [31:0] x;
	reg  [31:0] y;
	reg         cin;
	reg  [4:0]  carry;
	reg  [8:0]  part;
	reg         brk;
	integer     k;

	always @* begin
		x = i_a;
		y = i_b;
		cin = 1'b0;
		case (i_op)
			`RLE_OP_ADD:      begin x = i_a;  y = i_b;  cin = 1'b0; end
			`RLE_OP_SUB:      begin x = i_a;  y = ~i_b; cin = 1'b1; end
			`RLE_OP_RSUB:     begin x = ~i_a; y = i_b;  cin = 1'b1; end
			`RLE_OP_INCR:     begin x = 32'h00000000; y = i_b; cin = 1'b1; end
			`RLE_OP_DECR:     begin x = 32'hffffffff; y = i_b; cin = 1'b0; end
			`RLE_OP_ADDINCR:  begin x = i_a;  y = i_b;  cin = 1'b1; end
			`RLE_OP_SUBDECR:  begin x = i_a;  y = ~i_b; cin = 1'b0; end
			`RLE_OP_RSUBDECR: begin x = ~i_a; y = i_b;  cin = 1'b0; end
			default:          begin x = i_a;  y = i_b;  cin = 1'b0; end
		endcase
	end

	reg [31:0] sum;
	always @* begin
		carry = 5'h00;
		carry[0] = cin;
		sum = 32'h00000000;
		part = 9'h000;
		brk = 1'b0;
		for (k = 0; k < 4; k = k + 1) begin
			part = {1'b0, x[8*k +: 8]} + {1'b0, y[8*k +: 8]} + {8'h00, carry[k]};
			sum[8*k +: 8] = part[7:0];
			// Lane boundary restarts carry from the op's carry-in
			brk = (i_size == `RLE_SIZE_8) || ((i_size == `RLE_SIZE_16) && (k == 1));
			carry[k+1] = brk ? cin : part[8];
		end
	end

	// ----------------------------------------
	// Result select
	// ----------------------------------------
	always @* begin
		case (i_op)
			`RLE_OP_ADD, `RLE_OP_SUB, `RLE_OP_RSUB, `RLE_OP_INCR, `RLE_OP_DECR,
			`RLE_OP_ADDINCR, `RLE_OP_SUBDECR, `RLE_OP_RSUBDECR: o_y = sum;
			`RLE_OP_CLEAR:  o_y = 32'h00000000;
			`RLE_OP_SET:    o_y = 32'hffffffff;
			`RLE_OP_INVERT: o_y = ~i_b;
			`RLE_OP_AND:    o_y = i_a & i_b;
			`RLE_OP_NAND:   o_y = ~(i_a & i_b);
			`RLE_OP_OR:     o_y = i_a | i_b;
			`RLE_OP_NOR:    o_y = ~(i_a | i_b);
			`RLE_OP_XOR:    o_y = i_a ^ i_b;
			`RLE_OP_EQUIV:  o_y = ~(i_a ^ i_b);
			`RLE_OP_ANDREV: o_y = ~i_a & i_b;
			`RLE_OP_ANDINV: o_y = i_a & ~i_b;
			`RLE_OP_ORREV:  o_y = ~i_a | i_b;
			`RLE_OP_ORINV:  o_y = i_a | ~i_b;
			default:        o_y = i_b;
		endcase
	end
endmodule

// [rle_exec.v]
`timescale 1ns/1ps
`include "rle_regs.vh"
module rle_exec #(
	parameter RW = 6
) (
	input  wire               i_ref_clk,
	input  wire               i_rstn,
	input  wire               i_valid,
	input  wire [`RLE_OP_W-1:0] i_op,
	input  wire [1:0]         i_size,
	input  wire [RW-1:0]      i_dst,
	input  wire [3:0]         i_count,
	input  wire [8*RW-1:0]    i_list,
	input  wire [31:0]        i_first_operand,
	input  wire [31:0]        i_second_operand,
	input  wire [31:0]        i_src_data,
	input  wire [31:0]        i_list_data,
	input  wire [31:0]        i_mem_rdata,
	output wire               o_busy,
	output wire               o_done,
	output reg  [2:0]         o_list_idx,
	output reg                o_rf_we,
	output reg  [RW-1:0]      o_rf_waddr,
	output reg  [31:0]        o_rf_wdata,
	output reg                o_mem_we,
	output reg                o_mem_re,
	output reg  [31:0]        o_mem_addr,
	output reg  [31:0]        o_mem_wdata
);
	// i_first_operand is a general register or immediate, chosen upstream;
	// i_second_operand / i_dst address general or control space.

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam S_IDLE  = 4'b0001;
	localparam S_PUSH  = 4'b0010;
	localparam S_POP   = 4'b0100;
	localparam S_SWAP  = 4'b1000;

	reg  [3:0]  state_r,   state_nxt;
	reg  [3:0]  left_r,    left_nxt;
	reg  [31:0] sp_r,      sp_nxt;
	reg  [RW-1:0] sp_reg_r, sp_reg_nxt;
	reg  [RW-1:0] oth_r,   oth_nxt;
	reg  [31:0] hold_r,    hold_nxt;
	reg  [2:0]  idx_nxt;
	reg         rf_we_nxt;
	reg  [RW-1:0] rf_waddr_nxt;
	reg  [31:0] rf_wdata_nxt;
	reg         mem_we_nxt;
	reg         mem_re_nxt;
	reg  [31:0] mem_addr_nxt;
	reg  [31:0] mem_wdata_nxt;
	reg         pend_r,    pend_nxt;
	reg  [RW-1:0] pend_a_r, pend_a_nxt;
	reg         done_r,    done_nxt;

	wire [31:0] alu_y;

	rle_lane_alu u_alu (
		.i_op (i_op),
		.i_size (i_size),
		.i_a (i_first_operand),
		.i_b (i_second_operand),
		.o_y (alu_y)
	);

	// ----------------------------------------
	// Packed address formation
	// ----------------------------------------
	function [31:0] pack_addr;
		input       three_d;
		input [31:0] v;
		begin
			if (three_d)
				pack_addr = {8'h00, v[`RLE_A3_X_HI:`RLE_A3_X_LO],
					v[`RLE_A3_Y_HI:`RLE_A3_Y_LO], v[`RLE_A3_Z_HI:`RLE_A3_Z_LO]};
			else
				pack_addr = {v[`RLE_A2_X_HI:`RLE_A2_X_LO], v[`RLE_A2_Y_HI:`RLE_A2_Y_LO]};
		end
	endfunction

	function [RW-1:0] list_at;
		input [8*RW-1:0] l;
		input [2:0]      n;
		begin
			list_at = l[n*RW +: RW];
		end
	endfunction

	assign o_busy = (state_r != S_IDLE);
	assign o_done = done_r;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always @* begin
		state_nxt = state_r;
		left_nxt = left_r;
		sp_nxt = sp_r;
		sp_reg_nxt = sp_reg_r;
		oth_nxt = oth_r;
		hold_nxt = hold_r;
		idx_nxt = o_list_idx;
		rf_we_nxt = 1'b0;
		rf_waddr_nxt = o_rf_waddr;
		rf_wdata_nxt = o_rf_wdata;
		mem_we_nxt = 1'b0;
		mem_re_nxt = 1'b0;
		mem_addr_nxt = o_mem_addr;
		mem_wdata_nxt = o_mem_wdata;
		pend_nxt = 1'b0;
		pend_a_nxt = pend_a_r;
		done_nxt = 1'b0;
		case (state_r)
			S_IDLE: begin
				if (i_valid) begin
					case (i_op)
						`RLE_OP_NOP: done_nxt = 1'b1;
						`RLE_OP_STD: begin
							mem_we_nxt = 1'b1;
							mem_addr_nxt = i_first_operand;
							mem_wdata_nxt = i_src_data;
							done_nxt = 1'b1;
						end
						`RLE_OP_ADDR2D, `RLE_OP_ADDR3D: begin
							rf_we_nxt = 1'b1;
							rf_waddr_nxt = i_dst;
							rf_wdata_nxt = pack_addr(i_op == `RLE_OP_ADDR3D, i_first_operand);
							done_nxt = 1'b1;
						end
						`RLE_OP_MOVE: begin
							rf_we_nxt = 1'b1;
							rf_waddr_nxt = i_dst;
							rf_wdata_nxt = i_second_operand;
							done_nxt = 1'b1;
						end
						`RLE_OP_MOVI: begin
							rf_we_nxt = 1'b1;
							rf_waddr_nxt = i_dst;
							rf_wdata_nxt = i_first_operand;
							done_nxt = 1'b1;
						end
						`RLE_OP_SWAP: begin
							// First cycle: dst gets the general reg, then slot 0 gets old dst
							rf_we_nxt = 1'b1;
							rf_waddr_nxt = i_dst;
							rf_wdata_nxt = i_first_operand;
							hold_nxt = i_second_operand;
							oth_nxt = list_at(i_list, 3'h0);
							state_nxt = S_SWAP;
						end
						`RLE_OP_PUSH, `RLE_OP_POP: begin
							sp_nxt = i_second_operand;
							sp_reg_nxt = i_dst;
							left_nxt = (i_count == 4'h0) ? 4'h1 :
								((i_count > 4'h8) ? 4'h8 : i_count);
							idx_nxt = 3'h0;
							state_nxt = (i_op == `RLE_OP_PUSH) ? S_PUSH : S_POP;
						end
						default: begin
							rf_we_nxt = 1'b1;
							rf_waddr_nxt = i_dst;
							rf_wdata_nxt = alu_y;
							done_nxt = 1'b1;
						end
					endcase
				end
			end
			S_SWAP: begin
				rf_we_nxt = 1'b1;
				rf_waddr_nxt = oth_r;
				rf_wdata_nxt = hold_r;
				done_nxt = 1'b1;
				state_nxt = S_IDLE;
			end
			S_PUSH: begin
				// One word per cycle, pointer pre-decremented
				sp_nxt = sp_r - `RLE_WORD_BYTES;
				mem_we_nxt = 1'b1;
				mem_addr_nxt = sp_r - `RLE_WORD_BYTES;
				mem_wdata_nxt = i_list_data;
				left_nxt = left_r - 4'h1;
				idx_nxt = o_list_idx + 3'h1;
				if (left_r == 4'h1) begin
					rf_we_nxt = 1'b1;
					rf_waddr_nxt = sp_reg_r;
					rf_wdata_nxt = sp_r - `RLE_WORD_BYTES;
					done_nxt = 1'b1;
					idx_nxt = 3'h0;
					state_nxt = S_IDLE;
				end
			end
			S_POP: begin
				// Read issued now, its word lands a cycle later
				if (pend_r) begin
					rf_we_nxt = 1'b1;
					rf_waddr_nxt = pend_a_r;
					rf_wdata_nxt = i_mem_rdata;
				end
				if (left_r != 4'h0) begin
					mem_re_nxt = 1'b1;
					mem_addr_nxt = sp_r;
					sp_nxt = sp_r + `RLE_WORD_BYTES;
					pend_nxt = 1'b1;
					pend_a_nxt = list_at(i_list, o_list_idx);
					left_nxt = left_r - 4'h1;
					idx_nxt = o_list_idx + 3'h1;
				end else if (!pend_r) begin
					rf_we_nxt = 1'b1;
					rf_waddr_nxt = sp_reg_r;
					rf_wdata_nxt = sp_r;
					done_nxt = 1'b1;
					idx_nxt = 3'h0;
					state_nxt = S_IDLE;
				end
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= S_IDLE;
			left_r <= 4'h0;
			sp_r <= `RLE_RESET_WORD;
			sp_reg_r <= {RW{1'b0}};
			oth_r <= {RW{1'b0}};
			hold_r <= `RLE_RESET_WORD;
			o_list_idx <= 3'h0;
			o_rf_we <= 1'b0;
			o_rf_waddr <= {RW{1'b0}};
			o_rf_wdata <= `RLE_RESET_WORD;
			o_mem_we <= 1'b0;
			o_mem_re <= 1'b0;
			o_mem_addr <= `RLE_RESET_WORD;
			o_mem_wdata <= `RLE_RESET_WORD;
			pend_r <= 1'b0;
			pend_a_r <= {RW{1'b0}};
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			left_r <= left_nxt;
			sp_r <= sp_nxt;
			sp_reg_r <= sp_reg_nxt;
			oth_r <= oth_nxt;
			hold_r <= hold_nxt;
			o_list_idx <= idx_nxt;
			o_rf_we <= rf_we_nxt;
			o_rf_waddr <= rf_waddr_nxt;
			o_rf_wdata <= rf_wdata_nxt;
			o_mem_we <= mem_we_nxt;
			o_mem_re <= mem_re_nxt;
			o_mem_addr <= mem_addr_nxt;
			o_mem_wdata <= mem_wdata_nxt;
			pend_r <= pend_nxt;
			pend_a_r <= pend_a_nxt;
			done_r <= done_nxt;
		end
	end
endmodule

// [rle_exec_chk.sv]
`timescale 1ns/1ps
`include "rle_regs.vh"
module rle_exec_chk #(
	parameter RW = 6
) (
	input wire		i_ref_clk,
	input wire		i_rstn,
	input wire		i_valid,
	input wire [4:0]	i_op,
	input wire [1:0]	i_size,
	input wire [RW-1:0]	i_dst,
	input wire [3:0]	i_count,
	input wire [8*RW-1:0]	i_list,
	input wire [31:0]	i_first_operand,
	input wire [31:0]	i_second_operand,
	input wire [31:0]	i_src_data,
	input wire		o_busy,
	input wire		o_done,
	input wire		o_rf_we,
	input wire [RW-1:0]	o_rf_waddr,
	input wire [31:0]	o_rf_wdata,
	input wire		o_mem_we,
	input wire		o_mem_re,
	input wire [31:0]	o_mem_addr,
	input wire [31:0]	o_mem_wdata
);
default clocking cb @(posedge i_ref_clk);
endclocking
default disable iff (!i_rstn);
sequence s_take(logic [4:0] o);
	i_valid && !o_busy && i_op == o;
endsequence
sequence s_pop_reads;
	(o_mem_re && o_mem_addr == $past(i_second_operand, 2))
	##1 (o_mem_re && o_mem_addr == $past(i_second_operand, 3) + 32'h4);
endsequence
a_add_result: assert property (s_take(`RLE_OP_ADD) ##0 i_size == `RLE_SIZE_32 |=>
	o_rf_we && o_rf_wdata == $past(i_first_operand + i_second_operand))
	else $error("add result wrong");
a_rsub_result: assert property (s_take(`RLE_OP_RSUB) ##0 i_size == `RLE_SIZE_32 |=>
	o_rf_wdata == $past(i_second_operand - i_first_operand))
	else $error("reverse subtract result wrong");
a_lane_add: assert property (s_take(`RLE_OP_ADD) ##0 i_size == `RLE_SIZE_16 |=>
	o_rf_wdata == {$past(i_first_operand[31:16] + i_second_operand[31:16]),
	$past(i_first_operand[15:0] + i_second_operand[15:0])})
	else $error("halfword lanes not independent");
a_store_word: assert property (s_take(`RLE_OP_STD) |=> o_mem_we && o_done &&
	o_mem_addr == $past(i_first_operand) && o_mem_wdata == $past(i_src_data))
	else $error("absolute store wrong");
a_imm_move: assert property (s_take(`RLE_OP_MOVI) |=> o_rf_we &&
	o_rf_waddr == $past(i_dst) && o_rf_wdata == $past(i_first_operand))
	else $error("immediate move wrong");
a_swap_pair: assert property (s_take(`RLE_OP_SWAP) |=>
	(o_rf_we && !o_done && o_rf_wdata == $past(i_first_operand)) ##1
	(o_rf_we && o_done && o_rf_waddr == i_list[RW-1:0] &&
	o_rf_wdata == $past(i_second_operand, 2)))
	else $error("swap sequence wrong");
a_addr3d_pack: assert property (s_take(`RLE_OP_ADDR3D) |=>
	o_rf_wdata == {8'h00, $past(i_first_operand[23:0])})
	else $error("3d address packing wrong");
a_push_eight: assert property (s_take(`RLE_OP_PUSH) ##0 i_count == 4'h8 |->
	##2 (!o_done)[*7] ##1 (o_done && o_mem_we && o_mem_addr == o_rf_wdata &&
	o_rf_wdata == $past(i_second_operand, 9) - 32'h20))
	else $error("eight-register push timing wrong");
a_pop_two: assert property (s_take(`RLE_OP_POP) ##0 i_count == 4'h2 |->
	##2 s_pop_reads ##2 (o_done && o_rf_we &&
	o_rf_wdata == $past(i_second_operand, 5) + 32'h8))
	else $error("two-register pop wrong");
endmodule
bind rle_exec rle_exec_chk #(.RW(RW)) chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
	.i_valid(i_valid), .i_op(i_op), .i_size(i_size), .i_dst(i_dst), .i_count(i_count),
	.i_list(i_list), .i_first_operand(i_first_operand),
	.i_second_operand(i_second_operand), .i_src_data(i_src_data), .o_busy(o_busy),
	.o_done(o_done), .o_rf_we(o_rf_we), .o_rf_waddr(o_rf_waddr),
	.o_rf_wdata(o_rf_wdata), .o_mem_we(o_mem_we), .o_mem_re(o_mem_re),
	.o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata));

// [rle_mem_model.sv]
`timescale 1ns/1ps
module rle_mem_model (
	input wire		i_ref_clk,
	input wire		i_we,
	input wire		i_re,
	input wire [31:0]	i_addr,
	input wire [31:0]	i_wdata,
	output logic [31:0]	o_rdata
);
logic [31:0]	mem [0:63];
logic [31:0]	idle_r;
initial idle_r = 32'h0;
// ----------------------------------------
// Read follows the registered address, scrambled when idle
// ----------------------------------------
always @(posedge i_ref_clk) begin
	if (i_we)
		mem[i_addr[7:2]] <= i_wdata;
	idle_r <= ~idle_r;
end
assign o_rdata = i_re ? mem[i_addr[7:2]] : idle_r;
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "rle_regs.vh"
module tb_top;
typedef struct {logic [4:0] op; logic [1:0] sz; logic [31:0] a, b, y;} rle_row_t;
localparam logic [31:0] LA = 32'h00ff00ff;
localparam logic [31:0] LB = 32'h0f0f0f0f;
logic		clk, rstn, valid;
logic [4:0]	op;
logic [1:0]	size;
logic [5:0]	dst, k;
logic [3:0]	cnt;
logic [47:0]	list;
logic [31:0]	fa, fb, src;
wire		busy, done, rf_we, mem_we, mem_re;
wire [2:0]	lidx;
wire [5:0]	waddr;
wire [31:0]	wdata, maddr, mwdata, rdat, ldat;
int		failures, compares, cyc;
logic [37:0]	q [$];
rle_row_t	rows [30] = '{
	'{`RLE_OP_ADD, 2'h0, 32'h1, 32'hffffffff, 32'h0},
	'{`RLE_OP_SUB, 2'h0, 32'h1, 32'hffffffff, 32'h2},
	'{`RLE_OP_RSUB, 2'h0, 32'h1, 32'hffffffff, 32'hfffffffe},
	'{`RLE_OP_INCR, 2'h0, 32'h1, 32'hffffffff, 32'h0},
	'{`RLE_OP_DECR, 2'h0, 32'h1, 32'hffffffff, 32'hfffffffe},
	'{`RLE_OP_ADDINCR, 2'h0, 32'h1, 32'hffffffff, 32'h1},
	'{`RLE_OP_SUBDECR, 2'h0, 32'h1, 32'hffffffff, 32'h1},
	'{`RLE_OP_RSUBDECR, 2'h0, 32'h1, 32'hffffffff, 32'hfffffffd},
	'{`RLE_OP_OR, 2'h0, LA, LB, 32'h0fff0fff},
	'{`RLE_OP_NOR, 2'h0, LA, LB, 32'hf000f000},
	'{`RLE_OP_XOR, 2'h0, LA, LB, 32'h0ff00ff0},
	'{`RLE_OP_EQUIV, 2'h0, LA, LB, 32'hf00ff00f},
	'{`RLE_OP_CLEAR, 2'h0, LA, LB, 32'h0},
	'{`RLE_OP_SET, 2'h0, LA, LB, 32'hffffffff},
	'{`RLE_OP_INVERT, 2'h0, LA, LB, 32'hf0f0f0f0},
	'{`RLE_OP_AND, 2'h0, LA, LB, 32'h000f000f},
	'{`RLE_OP_NAND, 2'h0, LA, LB, 32'hfff0fff0},
	'{`RLE_OP_ANDREV, 2'h0, LA, LB, 32'h0f000f00},
	'{`RLE_OP_ANDINV, 2'h0, LA, LB, 32'h00f000f0},
	'{`RLE_OP_ORREV, 2'h0, LA, LB, 32'hff0fff0f},
	'{`RLE_OP_ORINV, 2'h0, LA, LB, 32'hf0fff0ff},
	'{`RLE_OP_ADD, 2'h1, 32'h1, 32'h0000ffff, 32'h0},
	'{`RLE_OP_INCR, 2'h1, 32'h0, 32'h0, 32'h00010001},
	'{`RLE_OP_ADD, 2'h2, 32'h01010101, 32'h00ff00ff, 32'h01000100},
	'{`RLE_OP_SUB, 2'h2, 32'h0, 32'h1, 32'h000000ff},
	'{`RLE_OP_ADDINCR, 2'h2, 32'h0, 32'h000000ff, 32'h01010100},
	'{`RLE_OP_MOVE, 2'h0, 32'h0, LB, LB},
	'{`RLE_OP_MOVI, 2'h0, 32'h12345678, 32'h0, 32'h12345678},
	'{`RLE_OP_ADDR2D, 2'h0, 32'h12345678, 32'h0, 32'h12345678},
	'{`RLE_OP_ADDR3D, 2'h0, 32'h12345678, 32'h0, 32'h00345678}
};
assign ldat = 32'h5a000000 | {26'h0, list[lidx*6+:6]};
rle_exec uut (.i_ref_clk(clk), .i_rstn(rstn), .i_valid(valid), .i_op(op), .i_size(size),
	.i_dst(dst), .i_count(cnt), .i_list(list), .i_first_operand(fa),
	.i_second_operand(fb), .i_src_data(src), .i_list_data(ldat), .i_mem_rdata(rdat),
	.o_busy(busy), .o_done(done), .o_list_idx(lidx), .o_rf_we(rf_we),
	.o_rf_waddr(waddr), .o_rf_wdata(wdata), .o_mem_we(mem_we), .o_mem_re(mem_re),
	.o_mem_addr(maddr), .o_mem_wdata(mwdata));
rle_mem_model mem_m (.i_ref_clk(clk), .i_we(mem_we), .i_re(mem_re), .i_addr(maddr),
	.i_wdata(mwdata), .o_rdata(rdat));
initial begin
	clk = 1'b0;
	forever #50 clk = ~clk;
end
task automatic chk(input logic [63:0] got, input logic [63:0] exp);
	compares++;
	if (got !== exp)
		$display("unexpected at %0t: got %h expected %h", $time, got, exp);
	if (got !== exp)
		failures++;
endtask
task automatic go(input logic [4:0] o, input logic [3:0] n, input logic [5:0] d,
	input logic [31:0] a, input logic [31:0] b);
	@(posedge clk);
	valid <= 1'b1;
	op <= o;
	cnt <= n;
	dst <= d;
	fa <= a;
	fb <= b;
	q.delete();
	cyc = 0;
	do begin
		@(posedge clk);
		valid <= 1'b0;
		#1;
		cyc++;
		if (rf_we === 1'b1)
			q.push_back({waddr, wdata});
	end while (done !== 1'b1 && cyc < 20);
endtask
task automatic summarize;
	$display("compares %0d failures %0d", compares, failures);
	if (failures == 0 && compares > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
// ----------------------------------------
// Watchdog: about 60 cycles expected
// ----------------------------------------
initial begin
	#200000;
	failures++;
	summarize();
end
initial begin
	{rstn, valid, op, size, dst, fa, fb} = '0;
	cnt = 4'h1;
	list = {6'd8, 6'd7, 6'd6, 6'd5, 6'd4, 6'd3, 6'd2, 6'd1};
	src = 32'hcafef00d;
	@(posedge clk);
	#1;
	chk({busy, done, rf_we, mem_we, mem_re}, 0);
	@(posedge clk);
	rstn <= 1'b1;
	$display("test reset done");
	for (int i = 0; i <= 30; i++) begin
		@(posedge clk);
		valid <= (i < 30);
		if (i < 30) begin
			op <= rows[i].op;
			size <= rows[i].sz;
			fa <= rows[i].a;
			fb <= rows[i].b;
			dst <= 6'(i);
		end
		#1;
		k = 6'(i - 1);
		if (i > 0)
			chk({rf_we, done, waddr, wdata}, {2'b11, k, rows[i-1].y});
	end
	$display("test table done");
	size <= 2'h0;
	go(`RLE_OP_STD, 4'h1, 6'd0, 32'h10, 32'h0);
	chk(cyc, 1);
	@(posedge clk);
	#1;
	chk(mem_m.mem[4], 32'hcafef00d);
	$display("test store done");
	go(`RLE_OP_PUSH, 4'h8, 6'd30, 32'h0, 32'h100);
	chk(cyc, 9);
	@(posedge clk);
	#1;
	for (int j = 0; j < 8; j++)
		chk(mem_m.mem[63-j], 32'h5a000001 + j);
	chk(q[q.size()-1], {6'd30, 32'he0});
	go(`RLE_OP_POP, 4'h2, 6'd30, 32'h0, 32'he0);
	chk(cyc, 5);
	chk(q[0], {6'd1, 32'h5a000008});
	chk(q[1], {6'd2, 32'h5a000007});
	chk(q[2], {6'd30, 32'he8});
	go(`RLE_OP_PUSH, 4'h1, 6'd30, 32'h0, 32'h40);
	chk(cyc, 2);
	@(posedge clk);
	#1;
	chk(mem_m.mem[15], 32'h5a000001);
	$display("test stack done");
	go(`RLE_OP_SWAP, 4'h1, 6'd9, 32'h11, 32'h22);
	chk(cyc, 2);
	chk(q[0], {6'd9, 32'h11});
	chk(q[1], {6'd1, 32'h22});
	$display("test swap done");
	summarize();
end
endmodule
